// >>> core_defs.svh
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH

// Register bus geometry
`define AXIL_AW 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Register byte offsets
`define REG_ACC 8'h00
`define REG_PTR0 8'h04
`define REG_PTR1 8'h08
`define REG_OPTION 8'h0c
`define REG_IRQCTL 8'h10
`define REG_PWRCTL 8'h14
`define REG_PC 8'h18
`define REG_INSTR 8'h1c
`define REG_PUSH 8'h20
`define REG_FLAGS 8'h24
`define REG_STATUS 8'h28

// Operation codes in the instruction register
`define OP_IDLE 3'h0
`define OP_STORE 3'h1
`define OP_OPTION 3'h2
`define OP_SWRESET 3'h3
`define OP_RETIRQ 3'h4

// Pointer mode field encodings
`define MODE_PREINC 2'h0
`define MODE_PREDEC 2'h1
`define MODE_POSTINC 2'h2
`define MODE_POSTDEC 2'h3

// Field positions
`define IRQ_ENABLE_BIT 7
`define SWRST_IND_BIT 2
`define STAT_SP_LSB 16
`define STAT_BUSY_BIT 20

// Indirect window addresses, one per file pointer
`define IND0_ADDR 16'h0000
`define IND1_ADDR 16'h0001

// Reset values
`define ACC_RESET 8'h00
`define PTR_RESET 16'h0000
`define OPTION_RESET 8'hff
`define IRQCTL_RESET 8'h00
`define PWRCTL_RESET 8'h04
`define FLAGS_RESET 3'h0
`define PC_RESET 15'h0000

// Sizes
`define STACK_DEPTH 16
`define SP_W 4
`define PC_W 15

`endif

// >>> core_pkg.sv
`include "core_defs.svh"

package core_pkg;

    typedef enum logic {PH_READY, PH_RET2} phase_type;

    typedef struct packed {
        logic [2:0] op;
        logic ptr_idx;
        logic rel;
        logic [1:0] pointer_mode_field;
        logic [5:0] offset;
    } instr_type;

    typedef struct packed {
        logic awvalid;
        logic [`AXIL_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`AXIL_AW-1:0] araddr;
        logic rready;
    } axil_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_type;

    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [`AXIL_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wr_en;
        logic rd_pend;
        logic [`AXIL_AW-1:0] araddr;
        axil_rsp_type rsp;
    } slave_state_type;

    typedef struct packed {
        phase_type phase;
        logic [7:0] acc;
        logic [1:0][15:0] file_pointer;
        logic [7:0] option;
        logic [7:0] irq_control_reg;
        logic [7:0] power_control_reg;
        logic [2:0] flags;
        logic [`PC_W-1:0] pc;
        logic [`STACK_DEPTH-1:0][`PC_W-1:0] stack;
        logic [`SP_W-1:0] sp;
        logic [12:0] last_instr;
        logic [15:0] retired;
        logic mem_we;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic dev_reset;
    } core_state_type;

    // Offsets that answer OKAY; all others answer SLVERR
    function automatic logic addr_mapped(input logic [`AXIL_AW-1:0] a);
        unique case (a)
            `REG_ACC, `REG_PTR0, `REG_PTR1, `REG_OPTION, `REG_IRQCTL, `REG_PWRCTL,
            `REG_PC, `REG_INSTR, `REG_PUSH, `REG_FLAGS, `REG_STATUS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : addr_mapped

endpackage : core_pkg

// >>> pointer_step.sv
`timescale 1ns/10ps
`include "core_defs.svh"

// Effective address and next pointer value for the indirect store
module pointer_step (
    input wire logic [15:0] ptr, // Current file pointer
    input wire logic [1:0] pointer_mode_field, // Pre/post inc/dec select
    input wire logic rel, // Relative-offset form
    input wire logic [5:0] offset, // Signed offset, -32..31
    output logic [15:0] eff_addr, // Target address
    output logic [15:0] ptr_nxt // Pointer after the store
);
    logic [15:0] inc;
    logic [15:0] dec;
    logic [15:0] sext;

    // Sixteen-bit arithmetic wraps by itself at both ends
    always_comb begin
        inc = ptr + 16'h0001;
        dec = ptr - 16'h0001;
        sext = {{10{offset[5]}}, offset};
        eff_addr = ptr;
        ptr_nxt = ptr;
        if (rel) begin
            eff_addr = ptr + sext;
        end else begin
            unique case (pointer_mode_field)
                `MODE_PREINC: begin
                    eff_addr = inc;
                    ptr_nxt = inc;
                end
                `MODE_PREDEC: begin
                    eff_addr = dec;
                    ptr_nxt = dec;
                end
                `MODE_POSTINC: ptr_nxt = inc;
                `MODE_POSTDEC: ptr_nxt = dec;
            endcase
        end
    end

endmodule : pointer_step

// >>> axil_slave.sv
`timescale 1ns/10ps
`include "core_defs.svh"

// AXI4-Lite slave front end; one write and one read in flight at most
module axil_slave (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input wire core_pkg::axil_req_type req, // Master to slave channels
    output core_pkg::axil_rsp_type rsp, // Slave to master channels
    output logic wr_en, // One-cycle write strobe
    output logic [`AXIL_AW-1:0] wr_addr, // Write offset
    output logic [31:0] wr_data, // Write data
    output logic [3:0] wr_strb, // Byte enables
    output logic [`AXIL_AW-1:0] rd_addr, // Read offset
    input wire logic [31:0] rd_data // Read data for rd_addr
);
    core_pkg::slave_state_type s_r;
    core_pkg::slave_state_type s_nxt;

    // Address and data taken in either order, response after both
    always_comb begin
        s_nxt = s_r;
        s_nxt.wr_en = 1'b0;
        if (req.awvalid && s_r.rsp.awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = req.awaddr;
        end
        if (req.wvalid && s_r.rsp.wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = req.wdata;
            s_nxt.wstrb = req.wstrb;
        end
        if (s_r.rsp.bvalid && req.bready) begin
            s_nxt.rsp.bvalid = 1'b0;
        end
        if (s_r.aw_got && s_r.w_got) begin
            s_nxt.wr_en = 1'b1;
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.rsp.bvalid = 1'b1;
            s_nxt.rsp.bresp = core_pkg::addr_mapped(s_r.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (req.arvalid && s_r.rsp.arready) begin
            s_nxt.rd_pend = 1'b1;
            s_nxt.araddr = req.araddr;
        end
        if (s_r.rsp.rvalid && req.rready) begin
            s_nxt.rsp.rvalid = 1'b0;
        end
        if (s_r.rd_pend) begin
            s_nxt.rd_pend = 1'b0;
            s_nxt.rsp.rvalid = 1'b1;
            s_nxt.rsp.rdata = rd_data;
            s_nxt.rsp.rresp = core_pkg::addr_mapped(s_r.araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        // Readies registered so they come from flops; they close while a transfer is open
        s_nxt.rsp.awready = !s_nxt.aw_got && !s_nxt.rsp.bvalid && !s_nxt.wr_en;
        s_nxt.rsp.wready = !s_nxt.w_got && !s_nxt.rsp.bvalid && !s_nxt.wr_en;
        s_nxt.rsp.arready = !s_nxt.rd_pend && !s_nxt.rsp.rvalid;
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rsp = s_r.rsp;
    assign wr_en = s_r.wr_en;
    assign wr_addr = s_r.awaddr;
    assign wr_data = s_r.wdata;
    assign wr_strb = s_r.wstrb;
    assign rd_addr = s_r.araddr;

endmodule : axil_slave

// >>> store_return_core.sv
// Functional notes
// - Indirect store writes accumulator via pointer; mode 00/01/10/11 pre-inc/pre-dec/post-inc/post-dec.
// - Relative form targets pointer plus signed offset -32..31; pointer stays unchanged.
// - A one-bit index picks file pointer 0 or 1.
// - Indirect window has no storage; access goes to address the pointer holds.
// - File pointers are 16 bits and wrap at both ends.
// - Pointer step and indirect store leave zero, carry and digit carry alone.
// - Load-option copies accumulator to option register, flags unchanged.
// - Software reset acts as full hardware reset and clears the reset indicator.
// - Return-from-irq pops stack into PC, sets enable bit 7, takes two cycles.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "core_defs.svh"

module store_return_core (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire core_pkg::axil_req_type axil_req, // AXI4-Lite master channels
    output core_pkg::axil_rsp_type axil_rsp, // AXI4-Lite slave channels
    output logic mem_we, // One-cycle data memory write
    output logic [15:0] mem_addr, // Data memory address
    output logic [7:0] mem_wdata, // Data memory write data
    output logic [7:0] option_out, // Option configuration register
    output logic global_irq_enable, // Global interrupt enable
    output logic dev_reset // One-cycle device reset request
);
    core_pkg::core_state_type s_r;
    core_pkg::core_state_type s_nxt;
    core_pkg::instr_type instr;
    logic wr_en;
    logic [`AXIL_AW-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [`AXIL_AW-1:0] rd_addr;
    logic [31:0] rd_data;
    logic [15:0] eff_addr;
    logic [15:0] ptr_nxt;
    logic [15:0] sel_ptr;
    logic busy;
    logic launch;
    logic [31:0] merged;

    // Value of every register after hardware reset; software reset loads the same but clears the indicator
    function automatic core_pkg::core_state_type reset_state();
        core_pkg::core_state_type r;
        r = '0;
        r.phase = core_pkg::PH_READY;
        r.acc = `ACC_RESET;
        r.file_pointer = {`PTR_RESET, `PTR_RESET};
        r.option = `OPTION_RESET;
        r.irq_control_reg = `IRQCTL_RESET;
        r.power_control_reg = `PWRCTL_RESET;
        r.flags = `FLAGS_RESET;
        r.pc = `PC_RESET;
        return r;
    endfunction : reset_state

    // Byte-lane merge of a write into an old register value
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // Window addresses stand for the register the matching pointer names
    function automatic logic [15:0] redirect(input logic [15:0] a, input logic [1:0][15:0] fp);
        if (a == `IND0_ADDR) begin
            return fp[0];
        end else if (a == `IND1_ADDR) begin
            return fp[1];
        end
        return a;
    endfunction : redirect

    axil_slave u_slave (
        .clk_sys(clk_sys),
        .rst(rst),
        .req(axil_req),
        .rsp(axil_rsp),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // Decode of the instruction being written
    assign instr = core_pkg::instr_type'(wr_data[12:0]);
    assign busy = (s_r.phase != core_pkg::PH_READY);
    assign launch = wr_en && (wr_addr == `REG_INSTR) && !busy;
    assign sel_ptr = s_r.file_pointer[instr.ptr_idx];

    pointer_step u_step (
        .ptr(sel_ptr),
        .pointer_mode_field(instr.pointer_mode_field),
        .rel(instr.rel),
        .offset(instr.offset),
        .eff_addr(eff_addr),
        .ptr_nxt(ptr_nxt)
    );

    // Register read mux; unmapped offsets read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            `REG_ACC: rd_data[7:0] = s_r.acc;
            `REG_PTR0: rd_data[15:0] = s_r.file_pointer[0];
            `REG_PTR1: rd_data[15:0] = s_r.file_pointer[1];
            `REG_OPTION: rd_data[7:0] = s_r.option;
            `REG_IRQCTL: rd_data[7:0] = s_r.irq_control_reg;
            `REG_PWRCTL: rd_data[7:0] = s_r.power_control_reg;
            `REG_PC: rd_data[`PC_W-1:0] = s_r.pc;
            `REG_INSTR: rd_data[12:0] = s_r.last_instr;
            `REG_FLAGS: rd_data[2:0] = s_r.flags;
            `REG_STATUS: begin
                rd_data[15:0] = s_r.retired;
                rd_data[`STAT_SP_LSB +: `SP_W] = s_r.sp;
                rd_data[`STAT_BUSY_BIT] = busy;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Next state: register writes, then instruction execution
    always_comb begin
        s_nxt = s_r;
        s_nxt.mem_we = 1'b0;
        s_nxt.dev_reset = 1'b0;
        merged = 32'h0000_0000;
        // Second cycle of the return only retires it
        if (s_r.phase == core_pkg::PH_RET2) begin
            s_nxt.phase = core_pkg::PH_READY;
            s_nxt.retired = s_r.retired + 16'h0001;
        end
        if (wr_en) begin
            merged = lane_merge(rd_data_of(wr_addr), wr_data, wr_strb);
            unique case (wr_addr)
                `REG_ACC: s_nxt.acc = merged[7:0];
                `REG_PTR0: s_nxt.file_pointer[0] = merged[15:0];
                `REG_PTR1: s_nxt.file_pointer[1] = merged[15:0];
                `REG_OPTION: s_nxt.option = merged[7:0];
                `REG_IRQCTL: s_nxt.irq_control_reg = merged[7:0];
                `REG_PWRCTL: s_nxt.power_control_reg = merged[7:0];
                `REG_PC: s_nxt.pc = merged[`PC_W-1:0];
                `REG_FLAGS: s_nxt.flags = merged[2:0];
                `REG_PUSH: begin
                    // Fills the stack so a return has something to pop; overflow wraps
                    s_nxt.stack[s_r.sp] = merged[`PC_W-1:0];
                    s_nxt.sp = s_r.sp + `SP_W'(1);
                end
                default: ;
            endcase
        end
        // A new instruction is refused while a return is still running
        if (launch) begin
            s_nxt.last_instr = wr_data[12:0];
            s_nxt.retired = s_r.retired + 16'h0001;
            unique case (instr.op)
                `OP_STORE: begin
                    s_nxt.mem_we = 1'b1;
                    s_nxt.mem_wdata = s_r.acc;
                    s_nxt.mem_addr = redirect(eff_addr, s_r.file_pointer);
                    // Flags are not touched on this path
                    s_nxt.file_pointer[instr.ptr_idx] = ptr_nxt;
                end
                `OP_OPTION: s_nxt.option = s_r.acc;
                `OP_SWRESET: begin
                    // Same state as hardware reset, except the indicator now reads zero
                    s_nxt = reset_state();
                    s_nxt.power_control_reg[`SWRST_IND_BIT] = 1'b0;
                    s_nxt.dev_reset = 1'b1;
                end
                `OP_RETIRQ: begin
                    s_nxt.sp = s_r.sp - `SP_W'(1);
                    s_nxt.pc = s_r.stack[s_r.sp - `SP_W'(1)];
                    s_nxt.irq_control_reg[`IRQ_ENABLE_BIT] = 1'b1;
                    s_nxt.phase = core_pkg::PH_RET2;
                    s_nxt.retired = s_r.retired;
                end
                default: ; // Idle op and unused codes: only last_instr and retired move
            endcase
        end
    end

    // Current register contents by offset, for byte-lane merging
    function automatic logic [31:0] rd_data_of(input logic [`AXIL_AW-1:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            `REG_ACC: r[7:0] = s_r.acc;
            `REG_PTR0: r[15:0] = s_r.file_pointer[0];
            `REG_PTR1: r[15:0] = s_r.file_pointer[1];
            `REG_OPTION: r[7:0] = s_r.option;
            `REG_IRQCTL: r[7:0] = s_r.irq_control_reg;
            `REG_PWRCTL: r[7:0] = s_r.power_control_reg;
            `REG_PC: r[`PC_W-1:0] = s_r.pc;
            `REG_FLAGS: r[2:0] = s_r.flags;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : rd_data_of

    // State register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= reset_state();
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mem_we = s_r.mem_we;
    assign mem_addr = s_r.mem_addr;
    assign mem_wdata = s_r.mem_wdata;
    assign option_out = s_r.option;
    assign global_irq_enable = s_r.irq_control_reg[`IRQ_ENABLE_BIT];
    assign dev_reset = s_r.dev_reset;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence launch_store;
        launch && instr.op == `OP_STORE;
    endsequence

    sequence launch_ret;
        launch && instr.op == `OP_RETIRQ;
    endsequence

    a_store_data: assert property (launch_store |=> mem_we && mem_wdata == $past(s_r.acc))
        else $error("store did not write accumulator");

    a_preinc_addr: assert property (launch_store and (!instr.rel && instr.pointer_mode_field == `MODE_PREINC
        && sel_ptr + 16'h0001 > 16'h0001)
        |=> s_r.file_pointer[$past(instr.ptr_idx)] == $past(sel_ptr) + 16'h0001
        && mem_addr == $past(sel_ptr) + 16'h0001)
        else $error("pre-increment address or pointer wrong");

    a_rel_stable: assert property (launch_store and instr.rel |=> $stable(s_r.file_pointer))
        else $error("relative store moved a pointer");

    a_other_ptr: assert property (launch_store |=> s_r.file_pointer[!$past(instr.ptr_idx)]
        == $past(s_r.file_pointer[!instr.ptr_idx]))
        else $error("unselected pointer changed");

    a_window_redir: assert property (launch_store and eff_addr == `IND1_ADDR
        |=> mem_addr == $past(s_r.file_pointer[1]))
        else $error("window access not redirected");

    a_ptr_wrap: assert property (launch_store and (!instr.rel && instr.pointer_mode_field == `MODE_POSTINC
        && sel_ptr == 16'hffff) |=> s_r.file_pointer[$past(instr.ptr_idx)] == 16'h0000)
        else $error("pointer did not wrap");

    a_flags_kept: assert property (launch_store |=> $stable(s_r.flags))
        else $error("store changed flags");

    a_option_load: assert property (launch && instr.op == `OP_OPTION
        |=> option_out == $past(s_r.acc) && $stable(s_r.flags))
        else $error("option load wrong");

    a_sw_reset: assert property (launch && instr.op == `OP_SWRESET |=> dev_reset
        && !s_r.power_control_reg[`SWRST_IND_BIT] && s_r.acc == `ACC_RESET && option_out == `OPTION_RESET)
        else $error("software reset incomplete");

    a_ret_seq: assert property (launch_ret |=> busy && global_irq_enable
        && s_r.pc == $past(s_r.stack[s_r.sp - `SP_W'(1)]) ##1 !busy)
        else $error("return from irq wrong");

    a_idle_quiet: assert property (launch && instr.op == `OP_IDLE
        |=> !busy && !mem_we && $stable(s_r.acc) && $stable(s_r.file_pointer) && $stable(s_r.flags))
        else $error("idle op changed state");

endmodule : store_return_core

// >>> testbench.sv
`timescale 1ns/10ps
`include "core_defs.svh"

module testbench;
    logic clk_sys;
    logic rst;
    core_pkg::axil_req_type req;
    core_pkg::axil_rsp_type rsp;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] option_out;
    logic global_irq_enable;
    logic dev_reset;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int resets = 0;
    logic [33:0] rq[$];
    logic [23:0] mq[$];
    logic [1:0] bq[$];
    logic [31:0] seed = 32'h5f72;
    logic [15:0] base[4] = '{16'hfffe, 16'h0000, 16'hffff, 16'h8000};
    logic [15:0] eadr[4] = '{16'hffff, 16'hffff, 16'hffff, 16'h8000};
    logic [15:0] nptr[4] = '{16'hffff, 16'hffff, 16'h0000, 16'h7fff};

    store_return_core i_store_return_core (.clk_sys(clk_sys), .rst(rst), .axil_req(req), .axil_rsp(rsp),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .option_out(option_out),
        .global_irq_enable(global_irq_enable), .dev_reset(dev_reset));

    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // Write cycle; address and data released one by one as each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        logic b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        bq.push_back(er);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge clk_sys);
            if (aw && rsp.awready) begin
                aw = 1'b0;
                req.awvalid <= 1'b0;
            end
            if (w && rsp.wready) begin
                w = 1'b0;
                req.wvalid <= 1'b0;
            end
        end
        req.bready <= 1'b1;
        while (!b) begin
            @(posedge clk_sys);
            b = rsp.bvalid;
        end
        req.bready <= 1'b0;
    endtask : wr

    // Read cycle; expected answer noted for the watcher
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic t;
        t = 1'b0;
        rq.push_back({r, d});
        req.araddr <= a;
        req.arvalid <= 1'b1;
        while (!t) begin
            @(posedge clk_sys);
            t = rsp.arready;
        end
        req.arvalid <= 1'b0;
        req.rready <= 1'b1;
        t = 1'b0;
        while (!t) begin
            @(posedge clk_sys);
            t = rsp.rvalid;
        end
        req.rready <= 1'b0;
    endtask : rd

    task automatic op(input logic [2:0] o, input logic i, input logic rl, input logic [1:0] m, input logic [5:0] k);
        wr(`REG_INSTR, {19'h0, o, i, rl, m, k}, `RESP_OKAY);
    endtask : op

    // Watcher: pairs each result with the oldest note; unexpected writes fail
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 20000) begin
            num_errors++;
            close_out();
        end
        if (req.rready && rsp.rvalid) begin
            check("rdata", {rsp.rresp, rsp.rdata}, rq.size() > 0 ? rq.pop_front() : 34'hx);
        end
        if (req.bready && rsp.bvalid) begin
            check("bresp", rsp.bresp, bq.size() > 0 ? bq.pop_front() : 2'hx);
        end
        if (mem_we) begin
            check("memwr", {10'h0, mem_addr, mem_wdata}, mq.size() > 0 ? {10'h0, mq.pop_front()} : 34'hx);
        end
        if (dev_reset) begin
            resets++;
        end
    end

    // Main sequence
    initial begin
        logic [31:0] v;
        logic [7:0] acc;
        rst = 1'b1;
        req = '0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`REG_OPTION, 32'hff, `RESP_OKAY);
        rd(`REG_PWRCTL, 32'h04, `RESP_OKAY);
        rd(8'h2c, 32'h0, `RESP_SLVERR);
        wr(8'h30, rnd(), `RESP_SLVERR);
        wr(`REG_FLAGS, 32'h7, `RESP_OKAY);
        // Every pointer mode, both pointers; pre-decrement and post-increment at the wrap points
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            acc = v[7:0];
            wr(`REG_ACC, {24'h0, acc}, `RESP_OKAY);
            wr(i[0] ? `REG_PTR1 : `REG_PTR0, {16'h0, base[i]}, `RESP_OKAY);
            mq.push_back({eadr[i], acc});
            op(`OP_STORE, i[0], 1'b0, i[1:0], 6'h00);
            rd(i[0] ? `REG_PTR1 : `REG_PTR0, {16'h0, nptr[i]}, `RESP_OKAY);
        end
        rd(`REG_FLAGS, 32'h7, `RESP_OKAY);
        // Relative form at both offset limits
        wr(`REG_PTR1, 32'h4000, `RESP_OKAY);
        mq.push_back({16'h3fe0, acc});
        op(`OP_STORE, 1'b1, 1'b1, `MODE_POSTINC, 6'h20);
        mq.push_back({16'h401f, acc});
        op(`OP_STORE, 1'b1, 1'b1, `MODE_PREDEC, 6'h1f);
        rd(`REG_PTR1, 32'h4000, `RESP_OKAY);
        // Targets landing on the window go through the pointers
        wr(`REG_PTR0, 32'h0011, `RESP_OKAY);
        mq.push_back({16'h4000, acc});
        op(`OP_STORE, 1'b0, 1'b1, `MODE_PREINC, 6'h30);
        mq.push_back({16'h0011, acc});
        op(`OP_STORE, 1'b0, 1'b1, `MODE_POSTDEC, 6'h2f);
        v = rnd();
        acc = v[7:0];
        wr(`REG_ACC, {24'h0, acc}, `RESP_OKAY);
        op(`OP_OPTION, 1'b0, 1'b0, 2'h0, 6'h00);
        rd(`REG_OPTION, {24'h0, acc}, `RESP_OKAY);
        check("option_out", option_out, acc);
        rd(`REG_FLAGS, 32'h7, `RESP_OKAY);
        // Idle op: acc, pointer 0 and flags hold, no memory write appears
        op(`OP_IDLE, 1'b1, 1'b1, 2'h3, 6'h15);
        rd(`REG_ACC, {24'h0, acc}, `RESP_OKAY);
        rd(`REG_PTR0, 32'h0011, `RESP_OKAY);
        rd(`REG_FLAGS, 32'h7, `RESP_OKAY);
        // Return pops the pushed word; the PC holds the same value as the push data when it is pushed
        wr(`REG_PC, 32'h1234, `RESP_OKAY);
        wr(`REG_PUSH, 32'h1234, `RESP_OKAY);
        wr(`REG_PC, 32'h0005, `RESP_OKAY);
        op(`OP_RETIRQ, 1'b0, 1'b0, 2'h0, 6'h00);
        rd(`REG_PC, 32'h1234, `RESP_OKAY);
        rd(`REG_IRQCTL, 32'h80, `RESP_OKAY);
        check("global_irq_enable", global_irq_enable, 1'b1);
        // Software reset restores reset values but clears the indicator
        op(`OP_SWRESET, 1'b0, 1'b0, 2'h0, 6'h00);
        rd(`REG_ACC, 32'h0, `RESP_OKAY);
        check("dev_reset", resets, 34'h1);
        rd(`REG_OPTION, 32'hff, `RESP_OKAY);
        rd(`REG_PWRCTL, 32'h00, `RESP_OKAY);
        rd(`REG_STATUS, 32'h0, `RESP_OKAY);
        check("global_irq_enable", global_irq_enable, 1'b0);
        repeat (4) @(posedge clk_sys);
        check("pending", rq.size() + mq.size() + bq.size(), 34'h0);
        close_out();
    end
endmodule : testbench
